// ===== exp_cs_pkg.sv
// Shared constants and types for the expansion-bus chip-select block.
// Assumes a 32-bit register bus clocked at hclk and a 16-bit external data bus.
package exp_cs_pkg;

	// Number of chip selects and depth of the split-read FIFO.
	localparam int NUM_CS     = 8;
	localparam int FIFO_DEPTH = 8;

	// Control words sit at four times the chip select; status follows them.
	localparam logic [7:0] STATUS_OFFS = 8'h20;

	// Writable bits of a control word; the rest read as zero.
	localparam logic [31:0] CTRL_WMASK = 32'hBFFF_C03B;

	// Chip select 0 boots enabled, first processor style, slowest timing,
	// split off and write-protected; its width bit comes from the strap.
	localparam logic [31:0] CS0_RESET  = 32'hBFFF_0000;
	localparam logic [31:0] CSN_RESET  = 32'h0000_0000;

	// Cycles after reset release at which the synchronised strap is valid.
	localparam logic [1:0] STRAP_CAPTURE = 2'h2;

	// AHB transfer type bit that marks an active transfer (NONSEQ or SEQ).
	localparam int HTRANS_ACTIVE = 1;

	// Cycle styles held in the two-bit style field.
	typedef enum logic [1:0] {
		STYLE_UP_A  = 2'b00,
		STYLE_UP_B  = 2'b01,
		STYLE_HOST  = 2'b10,
		STYLE_RSVD  = 2'b11
	} style_type;

	// One chip-select timing and control word, most significant bit first.
	typedef struct packed {
		logic       enable;
		logic       rsvd30;
		logic [1:0] t_addr;
		logic [1:0] t_setup;
		logic [3:0] t_strobe;
		logic [1:0] t_hold;
		logic [3:0] t_recov;
		style_type  cycle_style_select;
		logic [7:0] rsvd13_6;
		logic       ready_pol;
		logic       mux;
		logic       split_en;
		logic       rsvd2;
		logic       write_en;
		logic       width8;
	} cs_cfg_type;

	// Expansion access request from the system bus side.
	typedef struct packed {
		logic        write;
		logic [2:0]  cs;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [2:0]  beats;
	} exp_req_type;

	// Answer kinds to an expansion request.
	typedef enum logic [2:0] {
		RSP_DONE       = 3'b000,
		RSP_ERROR      = 3'b001,
		RSP_RETRY      = 3'b010,
		RSP_SPLIT      = 3'b011,
		RSP_SPLIT_DONE = 3'b100
	} rsp_kind_type;

	typedef struct packed {
		logic         valid;
		rsp_kind_type kind;
	} exp_rsp_type;

	// Phases of one external cycle.
	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_ADDR   = 3'b001,
		PH_SETUP  = 3'b010,
		PH_STROBE = 3'b011,
		PH_HOLD   = 3'b100,
		PH_RECOV  = 3'b101
	} phase_type;

endpackage

// ===== exp_read_fifo.sv
// Read-data FIFO that gathers external beats before they go to the system bus.
// Assumes the writer never pushes when full and the reader never pops when empty.
`timescale 1ns/1ps
module exp_read_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// Write side.
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	// Read side.
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head_data,
	output logic                  empty
);
	localparam int AW = $clog2(DEPTH);

	// Power-of-two depth keeps pointer wrap free of compare logic.
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("exp_read_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      cnt_q;

	// Storage is not reset; only words under the count are ever read.
	always_ff @(posedge hclk) begin
		if (push)
			mem_q[wr_ptr_q] <= push_data;
	end

	// Pointers and fill count.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign head_data = mem_q[rd_ptr_q];
	assign empty     = (cnt_q == '0);

endmodule

// ===== exp_cs_ctrl.sv
// Expansion-bus chip-select controller: eight timing/control words on an
// AHB-Lite slave, an access request port, and the external cycle engine.
// Assumes one clock, asynchronous pins synchronised here, and a requester
// that drains read data before issuing another read.
//
// Functional notes
// - Eight independent control words, one per chip select 0 to 7.
// - Bits 15:14 pick style: processor A, processor B, host port, reserved.
// - Bit 4 set selects multiplexed address and data, clear non-multiplexed.
// - Bit 0 clear gives 16-bit data, set gives 8-bit data.
// - Address line 0 at reset release loads chip select 0 width bit.
// - Bit 31 enables the chip select; clear disables it.
// - Bit 3 permits split transfers for that chip select.
// - Only multi-word reads split; at most one split outstanding.
// - Split read is acknowledged, data gathered in eight-word FIFO, then completion; a retry due in the split's last cycle goes out instead of it.
// - Requests during an outstanding split get a retry answer.
// - Chip select 0 resets with split transfers disabled.
// - Bit 1 clear ignores writes to the region; set performs them.
// - Chip select 0 resets write-protected.
// - Host-port chip selects 4 to 7 stall on their own ready input.
// - Bit 5 sets ready polarity: 0 low means ready, 1 high.
// - Phase fields: address 29:28, setup 27:26, strobe 25:22, hold 21:20, recovery 19:16.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module exp_cs_ctrl #(
	parameter int FIFO_WORDS = exp_cs_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	// AHB-Lite register slave.
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	// Expansion access requests and answers.
	input  wire logic                    req_valid,
	input  wire exp_cs_pkg::exp_req_type req,
	output logic                         req_ready,
	output exp_cs_pkg::exp_rsp_type      rsp,
	input  wire logic                    rd_pop,
	output logic                         rd_valid,
	output logic [15:0]                  rd_data,
	// External pins.
	input  wire logic                    boot_width_strap,
	input  wire logic [3:0]              host_port_ready_in,
	input  wire logic [15:0]             ext_data_in,
	output logic [7:0]                   chip_select_out_n,
	output logic [23:0]                  ext_addr_out,
	output logic                         ale_out,
	output logic                         rd_strobe_n,
	output logic                         wr_strobe_n,
	output logic [15:0]                  ext_data_out,
	output logic                         ext_data_oe,
	output logic [1:0]                   cycle_style_out,
	output logic                         mux_out,
	output logic                         width8_out
);
	import exp_cs_pkg::*;

	initial begin
		if (FIFO_WORDS < FIFO_DEPTH)
			$error("exp_cs_ctrl: FIFO must hold a full eight-beat read");
	end

	// Ready polarity check for one chip select; ready is ignored outside host-port style.
	function automatic logic ready_ok(input cs_cfg_type c, input logic [2:0] cs,
	                                  input logic [3:0] rdy);
		return !(c.cycle_style_select == STYLE_HOST && cs[2])
		       || (rdy[cs[1:0]] == c.ready_pol);
	endfunction

	// Address step per beat follows the data width.
	function automatic logic [23:0] beat_step(input cs_cfg_type c);
		return c.width8 ? 24'h00_0001 : 24'h00_0002;
	endfunction

	// Pin synchronisers. The first stage feeds only the second.
	logic [3:0]  rdy_s1_q;
	logic [3:0]  rdy_s2_q;
	logic [15:0] din_s1_q;
	logic [15:0] din_s2_q;
	logic        strap_s1_q;
	logic        strap_s2_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_s1_q   <= '0;
			rdy_s2_q   <= '0;
			din_s1_q   <= '0;
			din_s2_q   <= '0;
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end else begin
			rdy_s1_q   <= host_port_ready_in;
			rdy_s2_q   <= rdy_s1_q;
			din_s1_q   <= ext_data_in;
			din_s2_q   <= din_s1_q;
			strap_s1_q <= boot_width_strap;
			strap_s2_q <= strap_s1_q;
		end
	end

	// AHB-Lite slave. Zero wait states: read data is prepared at the address
	// phase edge so it stands through the data phase.
	cs_cfg_type  cfg_q [NUM_CS];
	logic        wr_pend_q;
	logic [2:0]  wr_idx_q;
	logic [1:0]  strap_cnt_q;
	logic        ahb_take;
	logic [7:0]  ahb_offs;

	assign ahb_take = hsel && hready && htrans[HTRANS_ACTIVE];
	assign ahb_offs = haddr[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= '0;
		end else begin
			wr_pend_q <= ahb_take && hwrite && (ahb_offs < STATUS_OFFS)
			             && (haddr[31:8] == '0) && (ahb_offs[1:0] == 2'h0);
			wr_idx_q  <= ahb_offs[4:2];
		end
	end

	// Control words. The strap lands in chip select 0 once it has been
	// through the synchroniser, so it wins over a write in that cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_CS; i++)
				cfg_q[i] <= (i == 0) ? cs_cfg_type'(CS0_RESET) : cs_cfg_type'(CSN_RESET);
			strap_cnt_q <= '0;
		end else begin
			if (wr_pend_q)
				cfg_q[wr_idx_q] <= cs_cfg_type'(hwdata & CTRL_WMASK);
			if (strap_cnt_q != 2'h3)
				strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == STRAP_CAPTURE)
				cfg_q[0].width8 <= strap_s2_q;
		end
	end

	// Operation and phase engine state.
	phase_type   st_q;
	phase_type   st_d;
	logic [4:0]  cnt_q;
	logic [4:0]  cnt_d;
	cs_cfg_type  op_cfg_q;
	logic [2:0]  op_cs_q;
	logic        op_write_q;
	logic        op_split_q;
	logic [2:0]  beats_left_q;
	logic [23:0] addr_q;
	logic [15:0] wdata_q;
	logic        split_q;
	logic        blocking_q;
	logic        req_ready_q;
	exp_rsp_type rsp_q;
	logic        rd_valid_q;
	logic [15:0] rd_data_q;

	// Request decode against the addressed chip select.
	cs_cfg_type  ncfg;
	logic        take;
	logic        bad;
	logic        start;
	logic        last_done;
	logic        push;
	logic        drained;
	logic        fifo_empty;
	logic        fifo_pop;
	logic [15:0] fifo_head;
	logic [23:0] addr_nx;
	logic        split_rd;

	assign ncfg = cfg_q[req.cs];
	assign take = req_valid && req_ready_q;
	assign bad  = !ncfg.enable
	              || ncfg.cycle_style_select == STYLE_RSVD
	              || (ncfg.cycle_style_select == STYLE_HOST && !req.cs[2]);
	assign start = take && !bad && !split_q && (!req.write || ncfg.write_en);
	assign addr_nx = (st_q == PH_IDLE) ? req.addr : addr_q + beat_step(op_cfg_q);
	assign split_rd = !req.write && (req.beats != '0) && ncfg.split_en;

	// Next phase. Each phase lasts its field plus one; multiplexed mode adds
	// an address cycle; a host-port strobe holds until the DSP is ready.
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		push      = 1'b0;
		last_done = 1'b0;
		case (st_q)
			PH_IDLE: begin
				if (start) begin
					st_d  = PH_ADDR;
					cnt_d = 5'({3'h0, ncfg.t_addr}) + 5'({4'h0, ncfg.mux});
				end
			end
			PH_ADDR: begin
				if (cnt_q == '0) begin
					st_d  = PH_SETUP;
					cnt_d = 5'({3'h0, op_cfg_q.t_setup});
				end else
					cnt_d = cnt_q - 5'h1;
			end
			PH_SETUP: begin
				if (cnt_q == '0) begin
					st_d  = PH_STROBE;
					cnt_d = 5'({1'b0, op_cfg_q.t_strobe});
				end else
					cnt_d = cnt_q - 5'h1;
			end
			PH_STROBE: begin
				if (cnt_q != '0)
					cnt_d = cnt_q - 5'h1;
				else if (ready_ok(op_cfg_q, op_cs_q, rdy_s2_q)) begin
					st_d  = PH_HOLD;
					cnt_d = 5'({3'h0, op_cfg_q.t_hold});
					push  = !op_write_q;
				end
			end
			PH_HOLD: begin
				if (cnt_q == '0) begin
					st_d  = PH_RECOV;
					cnt_d = 5'({1'b0, op_cfg_q.t_recov});
				end else
					cnt_d = cnt_q - 5'h1;
			end
			PH_RECOV: begin
				if (cnt_q != '0)
					cnt_d = cnt_q - 5'h1;
				else if (beats_left_q != '0) begin
					st_d  = PH_ADDR;
					cnt_d = 5'({3'h0, op_cfg_q.t_addr}) + 5'({4'h0, op_cfg_q.mux});
				end else begin
					st_d      = PH_IDLE;
					last_done = 1'b1;
				end
			end
			default: begin
				st_d = PH_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q  <= PH_IDLE;
			cnt_q <= '0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Operation registers, latched at acceptance and stepped per beat.
	// Writes are always a single beat; only reads repeat.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_cfg_q     <= cs_cfg_type'(CSN_RESET);
			op_cs_q      <= '0;
			op_write_q   <= 1'b0;
			op_split_q   <= 1'b0;
			beats_left_q <= '0;
			addr_q       <= '0;
			wdata_q      <= '0;
		end else if (start) begin
			op_cfg_q     <= ncfg;
			op_cs_q      <= req.cs;
			op_write_q   <= req.write;
			op_split_q   <= split_rd;
			beats_left_q <= req.write ? 3'h0 : req.beats;
			addr_q       <= req.addr;
			wdata_q      <= req.wdata;
		end else if (st_q == PH_RECOV && st_d == PH_ADDR) begin
			beats_left_q <= beats_left_q - 3'h1;
			addr_q       <= addr_nx;
		end
	end

	// Outstanding split, blocking operation and request readiness. A split
	// read frees the request port at once so later requests can be retried;
	// any other cycle holds it until finished and its data are drained.
	assign drained = fifo_empty && !rd_valid_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			split_q     <= 1'b0;
			blocking_q  <= 1'b0;
			req_ready_q <= 1'b0;
		end else begin
			req_ready_q <= 1'b1;
			if (start && split_rd)
				split_q <= 1'b1;
			else if (split_q && st_q == PH_IDLE && drained)
				split_q <= 1'b0;
			if (start && !split_rd)
				blocking_q <= 1'b1;
			else if (blocking_q && st_q == PH_IDLE && drained)
				blocking_q <= 1'b0;
			if (start && !split_rd)
				req_ready_q <= 1'b0;
			else if (blocking_q && !(st_q == PH_IDLE && drained))
				req_ready_q <= 1'b0;
		end
	end

	// One-cycle answer pulse per retried, failed, ignored or split request and per finished cycle; a retry wins a tie.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= '{1'b0, RSP_DONE};
			if (take && split_q)
				rsp_q <= '{1'b1, RSP_RETRY};
			else if (take && bad)
				rsp_q <= '{1'b1, RSP_ERROR};
			else if (take && req.write && !ncfg.write_en)
				rsp_q <= '{1'b1, RSP_DONE};
			else if (start && split_rd)
				rsp_q <= '{1'b1, RSP_SPLIT};
			else if (last_done)
				rsp_q <= '{1'b1, op_split_q ? RSP_SPLIT_DONE : RSP_DONE};
		end
	end

	// Read gathering: each beat is captured at the end of its strobe. The
	// synchroniser adds two cycles, so a device must drive valid data
	// at least two cycles before its strobe ends.
	exp_read_fifo #(
		.WIDTH (16),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.push      (push),
		.push_data (op_cfg_q.width8 ? {8'h00, din_s2_q[7:0]} : din_s2_q),
		.pop       (fifo_pop),
		.head_data (fifo_head),
		.empty     (fifo_empty)
	);

	// Output stage so the read port is driven from flip-flops.
	assign fifo_pop = !fifo_empty && (!rd_valid_q || rd_pop);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= '0;
		end else if (fifo_pop) begin
			rd_valid_q <= 1'b1;
			rd_data_q  <= fifo_head;
		end else if (rd_pop) begin
			rd_valid_q <= 1'b0;
		end
	end

	// External pins, registered from the next phase so they change together.
	logic [7:0]  cs_n_q;
	logic        ale_q;
	logic        rd_n_q;
	logic        wr_n_q;
	logic [15:0] dout_q;
	logic        doe_q;
	logic        cs_phase;
	logic        nwrite;
	logic        nmux;
	logic [2:0]  ncs;

	assign cs_phase = (st_d == PH_SETUP) || (st_d == PH_STROBE) || (st_d == PH_HOLD);
	assign nwrite   = start ? req.write : op_write_q;
	assign nmux     = start ? ncfg.mux : op_cfg_q.mux;
	assign ncs      = start ? req.cs : op_cs_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_n_q <= 8'hFF;
			ale_q  <= 1'b0;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			dout_q <= '0;
			doe_q  <= 1'b0;
		end else begin
			cs_n_q <= cs_phase ? ~(8'h01 << ncs) : 8'hFF;
			// Latch enable drops one cycle before the address phase ends.
			ale_q  <= (st_d == PH_ADDR) && (cnt_d != '0) && nmux;
			rd_n_q <= !((st_d == PH_STROBE) && !nwrite);
			wr_n_q <= !((st_d == PH_STROBE) && nwrite);
			// Multiplexed mode puts the low address on the data bus first.
			if (st_d == PH_ADDR && nmux) begin
				dout_q <= addr_nx[15:0];
				doe_q  <= 1'b1;
			end else begin
				dout_q <= start ? req.wdata : wdata_q;
				doe_q  <= nwrite && (cs_phase || st_d == PH_ADDR);
			end
		end
	end

	// Register reads: control words, then status.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (ahb_take && !hwrite) begin
			hrdata <= '0;
			if (haddr[31:8] == '0 && ahb_offs < STATUS_OFFS)
				hrdata <= 32'(cfg_q[ahb_offs[4:2]]) & CTRL_WMASK;
			else if (haddr[31:8] == '0 && ahb_offs == STATUS_OFFS)
				hrdata <= {24'h00_0000, rd_valid_q, split_q, blocking_q,
				           fifo_empty, 1'b0, st_q};
		end
	end

	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign req_ready         = req_ready_q;
	assign rsp               = rsp_q;
	assign rd_valid          = rd_valid_q;
	assign rd_data           = rd_data_q;
	assign chip_select_out_n = cs_n_q;
	assign ext_addr_out      = addr_q;
	assign ale_out           = ale_q;
	assign rd_strobe_n       = rd_n_q;
	assign wr_strobe_n       = wr_n_q;
	assign ext_data_out      = dout_q;
	assign ext_data_oe       = doe_q;
	assign cycle_style_out   = op_cfg_q.cycle_style_select;
	assign mux_out           = op_cfg_q.mux;
	assign width8_out        = op_cfg_q.width8;

endmodule

// ===== exp_cs_sva.sv
// Checker for the request answers and the external pins of the controller.
// Assumes it is bound to every exp_cs_ctrl instance in the run.
`timescale 1ns/1ps
module exp_cs_sva (
	// Clock and reset.
	input wire logic                    hclk,
	input wire logic                    hresetn,
	// Request port.
	input wire logic                    req_valid,
	input wire exp_cs_pkg::exp_req_type req,
	input wire logic                    req_ready,
	input wire exp_cs_pkg::exp_rsp_type rsp,
	input wire logic                    rd_valid,
	// External pins.
	input wire logic [7:0]              chip_select_out_n,
	input wire logic                    rd_strobe_n,
	input wire logic                    wr_strobe_n,
	input wire logic                    ext_data_oe,
	input wire logic [1:0]              cycle_style_out
);
	import exp_cs_pkg::*;
	logic split_q;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A split counts as outstanding until its completion answer goes out.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			split_q <= 1'b0;
		else if (rsp.valid && rsp.kind == RSP_SPLIT)
			split_q <= 1'b1;
		else if (rsp.valid && rsp.kind == RSP_SPLIT_DONE)
			split_q <= 1'b0;
	end
	a_retry_in_split: assert property (split_q && req_valid && req_ready
		|=> rsp.valid && rsp.kind == RSP_RETRY) else $error("no retry in split");
	a_single_split: assert property (split_q
		|-> !(rsp.valid && rsp.kind == RSP_SPLIT)) else $error("second split accepted");
	a_split_reads_only: assert property (rsp.valid && rsp.kind == RSP_SPLIT
		|-> $past(req.write) == 1'b0 && $past(req.beats) != 3'h0) else $error("bad split");
	a_split_release: assert property (rsp.valid && rsp.kind == RSP_SPLIT
		|-> ##[0:2] req_ready) else $error("split kept bus");
	a_split_gathered: assert property (rsp.valid && rsp.kind == RSP_SPLIT_DONE
		|-> rd_valid) else $error("split done without data");
	a_one_select: assert property ($onehot0(~chip_select_out_n))
		else $error("two selects low");
	a_error_quiet: assert property (rsp.valid && rsp.kind == RSP_ERROR
		|-> chip_select_out_n == 8'hFF && rd_strobe_n && wr_strobe_n) else $error("error moved pins");
	a_style_legal: assert property (chip_select_out_n != 8'hFF
		|-> cycle_style_out != STYLE_RSVD && (chip_select_out_n[3:0] == 4'hF
		|| cycle_style_out != STYLE_HOST)) else $error("illegal style driven");
	a_strobe_selected: assert property (!rd_strobe_n || !wr_strobe_n
		|-> chip_select_out_n != 8'hFF) else $error("strobe unselected");
	a_write_drives: assert property (!wr_strobe_n |-> ext_data_oe)
		else $error("write without drive");
endmodule
bind exp_cs_ctrl exp_cs_sva u_sva (.hclk(hclk), .hresetn(hresetn), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .rsp(rsp), .rd_valid(rd_valid), .rd_strobe_n(rd_strobe_n),
	.chip_select_out_n(chip_select_out_n), .wr_strobe_n(wr_strobe_n),
	.ext_data_oe(ext_data_oe), .cycle_style_out(cycle_style_out));

// ===== ext_dev_model.sv
// Behavioural external devices: address-patterned read data and host ready.
// Assumes active-low chip selects and a controller that samples data late.
`timescale 1ns/1ps
module ext_dev_model (
	// Clock.
	input wire logic        hclk,
	// Controller pins.
	input wire logic [7:0]  chip_select_out_n,
	input wire logic [23:0] ext_addr_out,
	// Test controls.
	input wire logic        rdy_pol,
	input wire logic [3:0]  rdy_delay,
	// Answers.
	output logic     [15:0] ext_data_in,
	output logic     [3:0]  host_port_ready_in
);
	logic        sel;
	logic [15:0] last_q = 16'h0;
	logic [3:0]  wait_q = 4'h0;
	// Released lines toggle so a late sample never passes for real data.
	assign sel = chip_select_out_n != 8'hFF;
	assign ext_data_in = sel ? ext_addr_out[15:0] ^ 16'hA5A5 : ~last_q;
	// A slow device stays not ready until selected for rdy_delay cycles.
	assign host_port_ready_in = (wait_q >= rdy_delay) ? {4{rdy_pol}} : {4{~rdy_pol}};
	always_ff @(posedge hclk) begin
		last_q <= ext_data_in;
		wait_q <= !sel ? 4'h0 : (wait_q == 4'hF) ? wait_q : wait_q + 4'h1;
	end
endmodule

// ===== testbench.sv
// Self-checking bench for the chip-select controller.
// Assumes the checker is bound by its own file and the strap is tied high.
`timescale 1ns/1ps
module testbench;
	import exp_cs_pkg::*;
	typedef struct packed {
		logic [2:0] cs; logic en; style_type st; logic [5:0] low;
		logic wr; logic [2:0] beats; rsp_kind_type kind; logic cyc;
	} row_type;
	row_type rows [9] = '{
		'{3'h2, 1'h1, STYLE_UP_A, 6'h02, 1'h1, 3'h0, RSP_DONE, 1'h1},
		'{3'h2, 1'h0, STYLE_UP_A, 6'h02, 1'h1, 3'h0, RSP_ERROR, 1'h0},
		'{3'h2, 1'h1, STYLE_UP_A, 6'h00, 1'h1, 3'h0, RSP_DONE, 1'h0},
		'{3'h2, 1'h1, STYLE_RSVD, 6'h02, 1'h1, 3'h0, RSP_ERROR, 1'h0},
		'{3'h3, 1'h1, STYLE_HOST, 6'h02, 1'h1, 3'h0, RSP_ERROR, 1'h0},
		'{3'h3, 1'h1, STYLE_UP_B, 6'h12, 1'h1, 3'h0, RSP_DONE, 1'h1},
		'{3'h5, 1'h1, STYLE_HOST, 6'h20, 1'h0, 3'h1, RSP_DONE, 1'h1},
		'{3'h6, 1'h1, STYLE_HOST, 6'h01, 1'h0, 3'h2, RSP_DONE, 1'h1},
		'{3'h2, 1'h1, STYLE_UP_A, 6'h01, 1'h0, 3'h0, RSP_DONE, 1'h1}};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, req_valid, req_ready, rd_pop;
	logic rd_valid, rd_strobe_n, rdy_pol;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  rdy_delay, host_port_ready_in;
	logic [15:0] rd_data, ext_data_in;
	logic [7:0]  chip_select_out_n;
	logic [23:0] ext_addr_out;
	exp_req_type req;
	exp_rsp_type rsp;
	rsp_kind_type k;
	row_type r;
	int checks, mismatches, cyc_n, cs_cycles, strb, c0, s0, s1;
	exp_cs_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp(rsp), .rd_pop(rd_pop), .rd_valid(rd_valid),
		.rd_data(rd_data), .boot_width_strap(1'h1), .host_port_ready_in(host_port_ready_in),
		.ext_data_in(ext_data_in), .chip_select_out_n(chip_select_out_n),
		.ext_addr_out(ext_addr_out), .ale_out(), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(),
		.ext_data_out(), .ext_data_oe(), .cycle_style_out(), .mux_out(), .width8_out());
	ext_dev_model u_dev (.hclk(hclk), .chip_select_out_n(chip_select_out_n),
		.ext_addr_out(ext_addr_out), .rdy_pol(rdy_pol), .rdy_delay(rdy_delay),
		.ext_data_in(ext_data_in), .host_port_ready_in(host_port_ready_in));
	// Free-running clock.
	initial begin
		hclk = 1'h0;
		forever #2 hclk = ~hclk;
	end
	// Cycle counters; the ceiling cuts a hang short.
	always @(posedge hclk) begin
		cyc_n++;
		if (chip_select_out_n !== 8'hFF) cs_cycles++;
		if (rd_strobe_n === 1'h0) strb++;
		if (cyc_n == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One AHB-Lite single transfer; read data taken at data-phase end.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rdat = hrdata;
	endtask
	task automatic req_op(input logic w, input logic [2:0] cs, input logic [2:0] beats,
		output rsp_kind_type kind);
		@(posedge hclk);
		req_valid <= 1'h1;
		req <= '{w, cs, 24'h000100, 16'h5A5A, beats};
		do @(posedge hclk); while (req_ready !== 1'h1);
		req_valid <= 1'h0;
		do @(posedge hclk); while (rsp.valid !== 1'h1);
		kind = rsp.kind;
	endtask
	// Pops each beat and checks the device's address pattern.
	task automatic drain(input logic w8, input logic [2:0] beats);
		logic [15:0] e;
		for (int j = 0; j <= beats; j++) begin
			e = 16'(16'h0100 + j * (w8 ? 1 : 2)) ^ 16'hA5A5;
			if (w8) e[15:8] = 8'h00;
			do @(posedge hclk); while (rd_valid !== 1'h1);
			chk("read data", rd_data, e);
			rd_pop <= 1'h1;
			@(posedge hclk);
			rd_pop <= 1'h0;
		end
	endtask
	function automatic logic [31:0] cw(logic en, style_type st, logic [5:0] low);
		cs_cfg_type c;
		c = '0;
		c.enable = en;
		c.cycle_style_select = st;
		c.t_strobe = 4'h2;
		{c.ready_pol, c.mux, c.split_en, c.rsvd2, c.write_en, c.width8} = low;
		if (st == STYLE_HOST) {c.t_addr, c.t_setup} = 4'hA;
		return c;
	endfunction
	initial begin
		{hresetn, hsel, hwrite, req_valid, rd_pop, haddr, htrans, hwdata} = '0;
		{hsize, rdy_pol, rdy_delay, req} = {3'h2, 1'h1, 4'h0, 47'h0};
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		repeat (4) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			ahb(1'h0, 32'(i * 4), 32'h0, rd);
			chk("reset word", rd, (i == 0) ? 32'hBFFF_0001 : 32'h0);
		end
		ahb(1'h0, 32'h40, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		ahb(1'h1, 32'h1C, 32'hFFFF_FFFF, rd);
		ahb(1'h0, 32'h1C, 32'h0, rd);
		chk("field mask", rd, 32'hBFFF_C03B);
		// Boot select: writes dropped, reads whole and unsplit at strap width.
		c0 = cs_cycles;
		req_op(1'h1, 3'h0, 3'h0, k);
		chk("boot write", {k, cs_cycles == c0}, {RSP_DONE, 1'h1});
		req_op(1'h0, 3'h0, 3'h1, k);
		chk("boot read", k, RSP_DONE);
		drain(1'h1, 3'h1);
		foreach (rows[i]) begin
			r = rows[i];
			rdy_pol <= r.low[5];
			ahb(1'h1, {27'h0, r.cs, 2'h0}, cw(r.en, r.st, r.low), rd);
			c0 = cs_cycles;
			req_op(r.wr, r.cs, r.beats, k);
			chk("answer", k, r.kind);
			chk("cycle run", cs_cycles != c0, r.cyc);
			if (!r.wr && k === RSP_DONE) drain(r.low[0], r.beats);
		end
		// A slow host-port device must stretch the strobe.
		rdy_pol <= 1'h1;
		ahb(1'h1, 32'h10, cw(1'h1, STYLE_HOST, 6'h20), rd);
		s0 = strb;
		req_op(1'h0, 3'h4, 3'h0, k);
		drain(1'h0, 3'h0);
		s1 = strb - s0;
		rdy_delay <= 4'hE;
		s0 = strb;
		req_op(1'h0, 3'h4, 3'h0, k);
		drain(1'h0, 3'h0);
		chk("ready stall", strb - s0 > s1 + 4, 1'h1);
		// A full eight-beat split; a request meanwhile must be retried.
		ahb(1'h1, 32'h04, cw(1'h1, STYLE_UP_A, 6'h0A), rd);
		req_op(1'h0, 3'h1, 3'h7, k);
		chk("split", k, RSP_SPLIT);
		req_op(1'h1, 3'h2, 3'h0, k);
		chk("retry", k, RSP_RETRY);
		do @(posedge hclk); while (!(rsp.valid === 1'h1 && rsp.kind === RSP_SPLIT_DONE));
		drain(1'h0, 3'h7);
		ahb(1'h1, 32'h04, cw(1'h1, STYLE_UP_A, 6'h02), rd);
		req_op(1'h0, 3'h1, 3'h7, k);
		chk("no split", k, RSP_DONE);
		drain(1'h0, 3'h7);
		report_and_stop();
	end
endmodule
